/* File: tpcia_pkg.sv */
// tpcia_pkg: register map, field positions, reset values and timing for the
// transmit per-channel indirect access block.
// assumes: one 50 MHz clock, registers one per aligned 32-bit APB word.
package tpcia_pkg;

	// printed register offsets are indices; the byte address is four times the index
	localparam logic [9:0] CFG_IDX = 10'h06C;
	localparam logic [9:0] STAT_IDX = 10'h06D;
	localparam logic [9:0] ADDR_IDX = 10'h06E;
	localparam logic [9:0] DATA_IDX = 10'h06F;
	localparam logic [11:0] CFG_ADDR = {CFG_IDX, 2'b00};
	localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};
	localparam logic [11:0] ADDR_ADDR = {ADDR_IDX, 2'b00};
	localparam logic [11:0] DATA_ADDR = {DATA_IDX, 2'b00};

	// configuration fields
	localparam int CFG_APPLY_BIT = 0;
	localparam int CFG_IND_BIT = 1;
	localparam int CFG_RSVD_BIT = 2;
	localparam int CFG_W = 3;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// status and address/control fields
	localparam int STAT_BUSY_BIT = 7;
	localparam int AC_RNW_BIT = 7;
	localparam int AC_ADDR_W = 7;
	localparam logic [7:0] AC_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// internal address groups, 32 entries each
	localparam logic [1:0] GRP_CTRL = 2'h1;
	localparam logic [1:0] GRP_IDLE = 2'h2;
	localparam logic [1:0] GRP_SIG = 2'h3;
	localparam int SLOTS = 32;
	localparam int SLOT_W = 5;

	// access timing
	localparam int CLK_NS = 20;
	localparam int ACCESS_NS = 640;
	localparam int ACCESS_CYC = ACCESS_NS / CLK_NS;
	localparam logic [5:0] ACCESS_LAST = 6'(ACCESS_CYC - 1);
	localparam logic [5:0] COUNT_RESET = 6'h00;

	typedef enum logic [0:0] {TPCIA_IDLE, TPCIA_RUN} tpcia_state_t;

endpackage : tpcia_pkg

/* File: tpcia_store_if.sv */
// tpcia_store_if: carrier between the access engine and the per-channel store.
// assumes: both ends on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tpcia_store_if;
	logic a_we;
	logic [6:0] a_addr;
	logic [7:0] a_wdata;
	logic [7:0] a_rdata;
	logic [4:0] b_slot;
	logic [7:0] b_ctrl;
	logic [7:0] b_idle;
	logic [7:0] b_sig;

	modport engine (
		output a_we,
		output a_addr,
		output a_wdata,
		input a_rdata,
		output b_slot,
		input b_ctrl,
		input b_idle,
		input b_sig
	);
	modport store (
		input a_we,
		input a_addr,
		input a_wdata,
		output a_rdata,
		input b_slot,
		output b_ctrl,
		output b_idle,
		output b_sig
	);
endinterface : tpcia_store_if
`default_nettype wire

/* File: tpcia_store.sv */
// tpcia_store: per-timeslot control, idle-code and signaling bytes.
// assumes: engine writes only valid internal addresses; contents are not reset.
`timescale 1ns/1ns
`default_nettype none
module tpcia_store (
	input wire logic pclk,
	tpcia_store_if.store st
);
	logic [7:0] ctrl_mem [0:tpcia_pkg::SLOTS-1];
	logic [7:0] idle_mem [0:tpcia_pkg::SLOTS-1];
	logic [7:0] sig_mem [0:tpcia_pkg::SLOTS-1];
	wire [1:0] grp = st.a_addr[6:5];
	wire [4:0] idx = st.a_addr[4:0];

	////////////////////////////////////////////////////////////////////////////
	// three groups at 20H, 40H and 60H
	always_ff @(posedge pclk) begin
		if (st.a_we && grp == tpcia_pkg::GRP_CTRL) begin
			ctrl_mem[idx] <= st.a_wdata;
		end
		if (st.a_we && grp == tpcia_pkg::GRP_IDLE) begin
			idle_mem[idx] <= st.a_wdata;
		end
		if (st.a_we && grp == tpcia_pkg::GRP_SIG) begin
			sig_mem[idx] <= st.a_wdata;
		end
	end

	assign st.a_rdata = (grp == tpcia_pkg::GRP_CTRL) ? ctrl_mem[idx] :
		(grp == tpcia_pkg::GRP_IDLE) ? idle_mem[idx] :
		(grp == tpcia_pkg::GRP_SIG) ? sig_mem[idx] : 8'h00;

	// framer side reads all three bytes of one slot at once
	assign st.b_ctrl = ctrl_mem[st.b_slot];
	assign st.b_idle = idle_mem[st.b_slot];
	assign st.b_sig = sig_mem[st.b_slot];
endmodule : tpcia_store
`default_nettype wire

/* File: tpcia_top.sv */
// tpcia_top: APB register bank and indirect access engine for the transmit
// per-channel controller, plus the per-slot byte feed to the transmit framer.
// assumes: APB master on pclk; framer presents its slot number on pclk.
//
// Summary of operation
// - indirect select bit 1 is cleared by reset.
// - apply enable high forwards stored per-slot bytes to the framer unchanged.
// - apply enable low sends all-zero bytes to the framer instead.
// - status bit 7 reads busy while an indirect access is in progress.
// - busy clears on a clock edge once the access is done.
// - each access completes within 640 ns.
// - address/control write with valid address starts an internal access.
// - bit 7 high requests a read, low requests a write.
// - bits 6..0 give the internal register address.
// - address/control register acts only while indirect select is one.
// - a read places the internal byte in the data buffer within 640 ns.
// - control bytes at 20H, idle bytes at 40H, signaling at 60H, 32 each.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module tpcia_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] tx_slot,
	output logic [7:0] tx_ctrl_byte,
	output logic [7:0] tx_idle_byte,
	output logic [7:0] tx_sig_byte,
	output logic access_busy
);

	////////////////////////////////////////////////////////////////////////////
	// register state

	logic [2:0] cfg_reg;
	logic [7:0] addr_ctrl_reg;
	logic [7:0] data_buf_reg;
	logic busy_reg;
	tpcia_pkg::tpcia_state_t state_reg;
	tpcia_pkg::tpcia_state_t state_next;
	logic [5:0] count_reg;
	logic [5:0] count_next;
	logic op_read_reg;
	logic [6:0] op_addr_reg;
	logic [7:0] op_data_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pslverr_reg;
	logic pslverr_next;
	logic [7:0] tx_ctrl_reg;
	logic [7:0] tx_idle_reg;
	logic [7:0] tx_sig_reg;

	tpcia_store_if st ();

	tpcia_store u_store (
		.pclk(pclk),
		.st(st)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// the setup cycle is seen first; pready rises for exactly one access cycle
	wire setup_phase = psel && !penable;
	wire access_done = psel && penable && pready_reg;
	wire wr_en = access_done && pwrite && pstrb[0];

	wire hit_cfg = (paddr == tpcia_pkg::CFG_ADDR);
	wire hit_stat = (paddr == tpcia_pkg::STAT_ADDR);
	wire hit_addr = (paddr == tpcia_pkg::ADDR_ADDR);
	wire hit_data = (paddr == tpcia_pkg::DATA_ADDR);
	wire hit_any = hit_cfg || hit_stat || hit_addr || hit_data;

	wire ind_on = cfg_reg[tpcia_pkg::CFG_IND_BIT];
	wire apply_on = cfg_reg[tpcia_pkg::CFG_APPLY_BIT];

	wire wr_cfg = wr_en && hit_cfg;
	wire wr_addr = wr_en && hit_addr;
	wire wr_data = wr_en && hit_data;

	////////////////////////////////////////////////////////////////////////////
	// request start

	wire [6:0] req_addr = pwdata[6:0];
	wire req_read = pwdata[tpcia_pkg::AC_RNW_BIT];

	// only the 20H..7FH span holds per-slot bytes; lower addresses start nothing
	wire req_addr_ok = (req_addr[6:5] != 2'h0);

	// address/control is dead unless indirect mode is selected
	// a write during a running access is dropped whole
	wire ac_write_ok = wr_addr && ind_on && !busy_reg;
	wire start = ac_write_ok && req_addr_ok;

	wire at_last = (count_reg == tpcia_pkg::ACCESS_LAST);
	wire finish = (state_reg == tpcia_pkg::TPCIA_RUN) && at_last;

	////////////////////////////////////////////////////////////////////////////
	// access engine

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			tpcia_pkg::TPCIA_IDLE: begin
				count_next = tpcia_pkg::COUNT_RESET;
				if (start) begin
					state_next = tpcia_pkg::TPCIA_RUN;
				end
			end
			tpcia_pkg::TPCIA_RUN: begin
				// fixed length so completion always fits the 640 ns budget
				if (at_last) begin
					state_next = tpcia_pkg::TPCIA_IDLE;
					count_next = tpcia_pkg::COUNT_RESET;
				end else begin
					count_next = count_reg + 6'h01;
				end
			end
			default: begin
				state_next = tpcia_pkg::TPCIA_IDLE;
				count_next = tpcia_pkg::COUNT_RESET;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= tpcia_pkg::TPCIA_IDLE;
			count_reg <= tpcia_pkg::COUNT_RESET;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// busy set by start, cleared on the clock edge that ends the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
		end else if (start) begin
			busy_reg <= 1'b1;
		end else if (finish) begin
			busy_reg <= 1'b0;
		end
	end

	// the request is latched at start so later buffer writes cannot disturb it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_read_reg <= 1'b0;
			op_addr_reg <= 7'h00;
			op_data_reg <= 8'h00;
		end else if (start) begin
			op_read_reg <= req_read;
			op_addr_reg <= req_addr;
			op_data_reg <= data_buf_reg;
		end
	end

	// store port A: a write lands at the end of the access
	assign st.a_we = finish && !op_read_reg;
	assign st.a_addr = op_addr_reg;
	assign st.a_wdata = op_data_reg;

	////////////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= tpcia_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			cfg_reg <= pwdata[tpcia_pkg::CFG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ctrl_reg <= tpcia_pkg::AC_RESET;
		end else if (ac_write_ok) begin
			addr_ctrl_reg <= pwdata[7:0];
		end
	end

	// read completion wins over a software write in the same cycle so that
	// fetched data is never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_buf_reg <= tpcia_pkg::DATA_RESET;
		end else if (finish && op_read_reg) begin
			data_buf_reg <= st.a_rdata;
		end else if (wr_data) begin
			data_buf_reg <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB read data and answer

	always_comb begin
		prdata_next = 32'h00000000;
		if (hit_cfg) begin
			prdata_next[tpcia_pkg::CFG_W-1:0] = cfg_reg;
		end
		if (hit_stat) begin
			prdata_next[tpcia_pkg::STAT_BUSY_BIT] = busy_reg;
		end
		if (hit_addr) begin
			prdata_next[7:0] = addr_ctrl_reg;
		end
		if (hit_data) begin
			prdata_next[7:0] = data_buf_reg;
		end
	end

	assign pslverr_next = !hit_any;

	// read data is captured at the setup edge and held through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? 32'h00000000 : prdata_next;
			pready_reg <= 1'b1;
			pslverr_reg <= pslverr_next;
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign access_busy = busy_reg;

	////////////////////////////////////////////////////////////////////////////
	// framer feed

	assign st.b_slot = tx_slot;

	// zeros stand in for stored bytes until software arms the apply enable,
	// which hides uninitialised store contents from the framer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ctrl_reg <= 8'h00;
			tx_idle_reg <= 8'h00;
			tx_sig_reg <= 8'h00;
		end else if (apply_on) begin
			tx_ctrl_reg <= st.b_ctrl;
			tx_idle_reg <= st.b_idle;
			tx_sig_reg <= st.b_sig;
		end else begin
			tx_ctrl_reg <= 8'h00;
			tx_idle_reg <= 8'h00;
			tx_sig_reg <= 8'h00;
		end
	end

	assign tx_ctrl_byte = tx_ctrl_reg;
	assign tx_idle_byte = tx_idle_reg;
	assign tx_sig_byte = tx_sig_reg;

endmodule : tpcia_top
`default_nettype wire

/* File: tpcia_top_sva.sv */
// tpcia_top_sva: port-level checks of the indirect access bank.
// assumes: bound to tpcia_top; one clock pclk, async reset presetn.
`timescale 1ns/1ns
`default_nettype none
module tpcia_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [4:0] tx_slot,
	input wire logic [7:0] tx_ctrl_byte,
	input wire logic [7:0] tx_idle_byte,
	input wire logic [7:0] tx_sig_byte,
	input wire logic access_busy
);
	logic [2:0] cfg_q;
	logic [5:0] cnt_reg;
	logic wr;
	logic setup;
	logic mapped;
	logic start;
	assign wr = psel && penable && pready && pwrite && pstrb[0];
	assign setup = psel && !penable;
	// the four words sit at 0x1B0..0x1BC
	assign mapped = paddr[11:4] == 8'h1B && paddr[1:0] == 2'h0;
	assign start = wr && paddr == tpcia_pkg::ADDR_ADDR && cfg_q[1] && !access_busy && pwdata[6:5] != 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= tpcia_pkg::CFG_RESET;
			cnt_reg <= tpcia_pkg::COUNT_RESET;
		end else begin
			if (wr && paddr == tpcia_pkg::CFG_ADDR) begin
				cfg_q <= pwdata[2:0];
			end
			cnt_reg <= access_busy ? cnt_reg + 6'h01 : 6'h00;
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_access_ready: assert property (setup |=> pready)
		else $error("pready missing after setup");
	a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_cfg_readback: assert property (setup && !pwrite && paddr == tpcia_pkg::CFG_ADDR |=> prdata == {29'h0, cfg_q})
		else $error("config read mismatch");
	a_busy_start: assert property (start |=> access_busy)
		else $error("access did not start");
	a_busy_len: assert property ($fell(access_busy) |-> cnt_reg == 6'h20)
		else $error("busy length wrong");
	a_busy_bound: assert property (access_busy |-> cnt_reg < 6'h20)
		else $error("busy too long");
	a_no_start: assert property (wr && paddr == tpcia_pkg::ADDR_ADDR && !cfg_q[1] && !access_busy |=> !access_busy)
		else $error("access started without indirect select");
	a_zero_feed: assert property (!cfg_q[0] && $past(cfg_q[0]) == 1'b0
		|-> tx_ctrl_byte == 8'h00 && tx_idle_byte == 8'h00 && tx_sig_byte == 8'h00)
		else $error("bytes not zero with apply off");
	a_status_busy: assert property (setup && !pwrite && paddr == tpcia_pkg::STAT_ADDR ##1 access_busy
		|-> prdata == 32'h80)
		else $error("status busy not shown");
endmodule : tpcia_top_sva
bind tpcia_top tpcia_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .tx_slot, .tx_ctrl_byte, .tx_idle_byte, .tx_sig_byte, .access_busy);
`default_nettype wire

/* File: tpcia_tb_top.sv */
// tpcia_tb_top: directed APB test of the indirect access bank.
// assumes: tpcia_top answers every APB access with pready; 50 MHz pclk.
`timescale 1ns/1ns
`default_nettype none
module tpcia_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, access_busy, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [4:0] tx_slot;
	logic [7:0] tx_ctrl_byte, tx_idle_byte, tx_sig_byte;
	logic [7:0] val [1:3];
	int failures, n_tests, n;
	tpcia_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .tx_slot, .tx_ctrl_byte, .tx_idle_byte, .tx_sig_byte, .access_busy);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// read just after the edge, before the slave's flops update: the values it sampled
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready wait", k, 1);
	endtask : apb
	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rc
	task automatic wait_idle;
		n = 0;
		while (access_busy === 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
	endtask : wait_idle
	task automatic stop_test;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		stop_test();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		tx_slot = 5'h00;
		val[1] = 8'hA5;
		val[2] = 8'h3C;
		val[3] = 8'hC3;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rc("config", tpcia_pkg::CFG_ADDR, 32'h0);
		rc("buffer", tpcia_pkg::DATA_ADDR, 32'h0);
		apb(1'b0, 12'h1C0, 32'h0);
		chk("unmapped err", er, 1);
		apb(1'b1, tpcia_pkg::ADDR_ADDR, 32'hBF);
		@(negedge pclk);
		chk("busy ind off", access_busy, 0);
		rc("addr ind off", tpcia_pkg::ADDR_ADDR, 32'h0);
		apb(1'b1, tpcia_pkg::CFG_ADDR, 32'h2);
		rc("config", tpcia_pkg::CFG_ADDR, 32'h2);
		apb(1'b1, tpcia_pkg::ADDR_ADDR, 32'h05);
		@(negedge pclk);
		chk("busy low addr", access_busy, 0);
		for (int g = 1; g <= 3; g++) begin
			apb(1'b1, tpcia_pkg::DATA_ADDR, {24'h0, val[g]});
			apb(1'b1, tpcia_pkg::ADDR_ADDR, {24'h0, 1'b0, 2'(g), 5'h1F});
			@(negedge pclk);
			chk("busy start", access_busy, 1);
			wait_idle();
			chk("busy cycles", n, tpcia_pkg::ACCESS_CYC);
		end
		for (int g = 1; g <= 3; g++) begin
			apb(1'b1, tpcia_pkg::ADDR_ADDR, {24'h0, 1'b1, 2'(g), 5'h1F});
			apb(1'b1, tpcia_pkg::ADDR_ADDR, 32'h21);
			rc("status busy", tpcia_pkg::STAT_ADDR, 32'h80);
			wait_idle();
			rc("status idle", tpcia_pkg::STAT_ADDR, 32'h0);
			rc("read byte", tpcia_pkg::DATA_ADDR, {24'h0, val[g]});
			rc("addr kept", tpcia_pkg::ADDR_ADDR, {24'h0, 1'b1, 2'(g), 5'h1F});
		end
		tx_slot <= 5'h1F;
		@(posedge pclk);
		@(negedge pclk);
		chk("feed off", {tx_ctrl_byte, tx_idle_byte, tx_sig_byte}, 32'h0);
		apb(1'b1, tpcia_pkg::CFG_ADDR, 32'h3);
		@(posedge pclk);
		@(negedge pclk);
		chk("feed on", {tx_ctrl_byte, tx_idle_byte, tx_sig_byte}, {8'h0, val[1], val[2], val[3]});
		stop_test();
	end
endmodule : tpcia_tb_top
`default_nettype wire
